// ---- sas_cfg.svh ----
// Constants for the skip-and-subtract execution block.
// Assumes inclusion by its bare name from the package and the design modules.
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

`define SAS_DATA_W 8
`define SAS_ADDR_W 8
`define SAS_MEM_DEPTH 256
`define SAS_ACC_RST 8'h00
`define SAS_BYTE_ZERO 8'h00
`define SAS_BYTE_ONE 8'h01
`define SAS_SIGN_BIT 7
`define SAS_NIB_W 5
`define SAS_NIB_HI 4
`define SAS_NIB_LO 3

`endif

// ---- sas_pkg.sv ----
// Types shared by the skip-and-subtract execution block.
// Assumes sas_cfg.svh is on the include path.
`include "sas_cfg.svh"

package sas_pkg;

    // ----------------------------------------------------------------
    // Operation codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SAS_OP_INC_SKIP_ZERO = 3'h0,
        SAS_OP_INC_SKIP_ZERO_TO_ACC = 3'h1,
        SAS_OP_SKIP_NONZERO = 3'h2,
        SAS_OP_SUB_TO_ACC = 3'h3,
        SAS_OP_SUB_TO_MEM = 3'h4
    } sas_op_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        sas_op_t op;
        logic [`SAS_ADDR_W-1:0] addr;
    } sas_req_t;

    typedef struct packed {
        logic overflow_flag;
        logic z;
        logic aux_borrow_flag;
        logic c;
        logic signed_compare_flag;
        logic compare_zero_flag;
    } sas_flags_t;

    typedef struct packed {
        logic en;
        logic [`SAS_ADDR_W-1:0] addr;
        logic [`SAS_DATA_W-1:0] data;
    } sas_wr_t;

    typedef enum logic [1:0] {
        SAS_ST_IDLE = 2'h0,
        SAS_ST_EXEC = 2'h1,
        SAS_ST_DUMMY1 = 2'h3,
        SAS_ST_DUMMY2 = 2'h2
    } sas_state_t;

endpackage : sas_pkg

// ---- sas_dmem.sv ----
// Data memory: one write port, one read port with registered read data.
// Assumes a single clock; write and read of one address in one cycle reads the old byte.
`timescale 1ns/1ps
`include "sas_cfg.svh"

module sas_dmem #(
    parameter int DATA_W = `SAS_DATA_W,
    parameter int ADDR_W = `SAS_ADDR_W,
    parameter int DEPTH = `SAS_MEM_DEPTH
) (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0] rd_data_out
);

    logic [DATA_W-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rd_data_out <= mem_q[rd_addr_in];
    end

endmodule : sas_dmem

// ---- sas_exec.sv ----
// Execution of increment-and-skip, skip-if-nonzero and subtract operations.
// Assumes requests come from the core's fetch logic on clk_in; memory preload is only taken while idle.
//
// Summary of operation
// RULE1 - Increment-and-skip adds one to the memory byte, writes it back and skips when the sum is zero.
// RULE2 - A taken skip inserts a dummy cycle pair so the skipping operation lasts three instruction cycles.
// RULE3 - The accumulator variant puts the byte plus one in the accumulator, leaves memory alone, skips on zero.
// RULE4 - Skip-if-nonzero skips when the memory byte differs from zero and proceeds when it is zero.
// RULE5 - Subtract-to-accumulator writes accumulator minus the memory byte into the accumulator.
// RULE6 - Subtract-to-memory writes accumulator minus the memory byte into that memory byte.
// RULE7 - Both subtracts clear carry when the difference is negative and set it otherwise.
// RULE8 - Subtracts update all six status flags; the skip operations leave every flag unchanged.
// RULE9 - Zero follows a zero result, overflow signed overflow, and aux from the low nibble borrow.
`timescale 1ns/1ps
`include "sas_cfg.svh"

module sas_exec
    import sas_pkg::*;
#(
    parameter int DEPTH = `SAS_MEM_DEPTH
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire sas_req_t req_in,
    input wire sas_wr_t preload_in,
    input wire logic acc_load_in,
    input wire logic [`SAS_DATA_W-1:0] acc_load_data_in,
    output logic busy_out,
    output logic done_out,
    output logic skip_out,
    output logic dummy_out,
    output logic [`SAS_DATA_W-1:0] acc_out,
    output sas_flags_t flags_out
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_sub(input sas_op_t op);
        is_sub = (op == SAS_OP_SUB_TO_ACC) || (op == SAS_OP_SUB_TO_MEM);
    endfunction : is_sub

    function automatic logic is_inc(input sas_op_t op);
        is_inc = (op == SAS_OP_INC_SKIP_ZERO) || (op == SAS_OP_INC_SKIP_ZERO_TO_ACC);
    endfunction : is_inc

    sas_state_t state_q;
    sas_req_t req_q;
    logic [`SAS_DATA_W-1:0] acc_q;
    sas_flags_t flags_q;
    logic busy_q;
    logic done_q;
    logic skip_q;
    logic dummy_q;
    logic [`SAS_DATA_W-1:0] rd_data;
    logic [`SAS_DATA_W-1:0] inc_sum;
    logic [`SAS_DATA_W:0] diff9;
    logic [`SAS_NIB_W-1:0] nib_diff;
    logic [`SAS_DATA_W-1:0] diff;
    logic skip_take;
    logic exec;
    logic accept;
    logic mem_we;
    logic [`SAS_ADDR_W-1:0] mem_waddr;
    logic [`SAS_DATA_W-1:0] mem_wdata;
    logic [`SAS_ADDR_W-1:0] mem_raddr;
    sas_flags_t sub_flags;

    assign exec = (state_q == SAS_ST_EXEC);
    assign accept = (state_q == SAS_ST_IDLE) && req_valid_in;
    assign mem_raddr = accept ? req_in.addr : req_q.addr;

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    assign inc_sum = rd_data + `SAS_BYTE_ONE;
    assign diff9 = {1'b0, acc_q} - {1'b0, rd_data};
    assign diff = diff9[`SAS_DATA_W-1:0];
    assign nib_diff = {1'b0, acc_q[`SAS_NIB_LO:0]} - {1'b0, rd_data[`SAS_NIB_LO:0]};

    always_comb begin
        sub_flags.c = ~diff9[`SAS_DATA_W]; // [RULE7]
        sub_flags.z = (diff == `SAS_BYTE_ZERO); // [RULE9]
        sub_flags.aux_borrow_flag = ~nib_diff[`SAS_NIB_HI]; // [RULE9]
        sub_flags.overflow_flag = (acc_q[`SAS_SIGN_BIT] ^ rd_data[`SAS_SIGN_BIT])
            & (acc_q[`SAS_SIGN_BIT] ^ diff[`SAS_SIGN_BIT]); // [RULE9]
        sub_flags.signed_compare_flag = ~(sub_flags.overflow_flag ^ diff[`SAS_SIGN_BIT]); // [RULE8]
        sub_flags.compare_zero_flag = sub_flags.z; // [RULE8]
    end

    always_comb begin
        case (req_q.op)
            SAS_OP_INC_SKIP_ZERO: skip_take = (inc_sum == `SAS_BYTE_ZERO); // [RULE1]
            SAS_OP_INC_SKIP_ZERO_TO_ACC: skip_take = (inc_sum == `SAS_BYTE_ZERO); // [RULE3]
            SAS_OP_SKIP_NONZERO: skip_take = (rd_data != `SAS_BYTE_ZERO); // [RULE4]
            default: skip_take = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Memory write port: execution writes, otherwise preload while idle
    // ----------------------------------------------------------------
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = req_q.addr;
        mem_wdata = inc_sum;
        if (exec && req_q.op == SAS_OP_INC_SKIP_ZERO) begin
            mem_we = 1'b1; // [RULE1]
        end else if (exec && req_q.op == SAS_OP_SUB_TO_MEM) begin
            mem_we = 1'b1;
            mem_wdata = diff; // [RULE6]
        end else if (state_q == SAS_ST_IDLE && preload_in.en) begin
            mem_we = 1'b1;
            mem_waddr = preload_in.addr;
            mem_wdata = preload_in.data;
        end
    end

    sas_dmem #(
        .DATA_W(`SAS_DATA_W),
        .ADDR_W(`SAS_ADDR_W),
        .DEPTH(DEPTH)
    ) i_sas_dmem (
        .clk_in(clk_in),
        .we_in(mem_we),
        .wr_addr_in(mem_waddr),
        .wr_data_in(mem_wdata),
        .rd_addr_in(mem_raddr),
        .rd_data_out(rd_data)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= SAS_ST_IDLE;
        end else begin
            case (state_q)
                SAS_ST_IDLE: state_q <= req_valid_in ? SAS_ST_EXEC : SAS_ST_IDLE;
                SAS_ST_EXEC: state_q <= skip_take ? SAS_ST_DUMMY1 : SAS_ST_IDLE; // [RULE2]
                SAS_ST_DUMMY1: state_q <= SAS_ST_DUMMY2; // [RULE2]
                SAS_ST_DUMMY2: state_q <= SAS_ST_IDLE;
                default: state_q <= SAS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            req_q <= '0;
        end else if (accept) begin
            req_q <= req_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            skip_q <= 1'b0;
            dummy_q <= 1'b0;
        end else begin
            busy_q <= accept || (busy_q && !done_q && !(exec && !skip_take) && state_q != SAS_ST_DUMMY2);
            done_q <= (exec && !skip_take) || state_q == SAS_ST_DUMMY2;
            skip_q <= state_q == SAS_ST_DUMMY2;
            dummy_q <= (exec && skip_take) || state_q == SAS_ST_DUMMY1; // [RULE2]
        end
    end

    // ----------------------------------------------------------------
    // Accumulator and status flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            acc_q <= `SAS_ACC_RST;
        end else if (exec && req_q.op == SAS_OP_INC_SKIP_ZERO_TO_ACC) begin
            acc_q <= inc_sum; // [RULE3]
        end else if (exec && req_q.op == SAS_OP_SUB_TO_ACC) begin
            acc_q <= diff; // [RULE5]
        end else if (state_q == SAS_ST_IDLE && acc_load_in) begin
            acc_q <= acc_load_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            flags_q <= '0;
        end else if (exec && is_sub(req_q.op)) begin
            flags_q <= sub_flags; // [RULE8]
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
    assign skip_out = skip_q;
    assign dummy_out = dummy_q;
    assign acc_out = acc_q;
    assign flags_out = flags_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_dummy_pair;
        dummy_out [*2] ##1 (done_out && skip_out && !dummy_out);
    endsequence

    a_inc_mem_write: assert property (exec && req_q.op == SAS_OP_INC_SKIP_ZERO |-> // [RULE1]
        mem_we && mem_wdata == rd_data + `SAS_BYTE_ONE && skip_take == (rd_data == ~`SAS_BYTE_ZERO))
        else $error("increment did not write back its sum");
    a_skip_three_cycles: assert property (exec && skip_take |=> s_dummy_pair) // [RULE2]
        else $error("taken skip did not last three cycles");
    a_noskip_one_cycle: assert property (exec && !skip_take |=> done_out && !skip_out && !dummy_out) // [RULE2]
        else $error("plain completion was delayed");
    a_inc_acc_result: assert property (exec && req_q.op == SAS_OP_INC_SKIP_ZERO_TO_ACC |-> // [RULE3]
        !mem_we ##1 acc_out == $past(rd_data) + `SAS_BYTE_ONE)
        else $error("accumulator increment wrong or memory touched");
    a_nonzero_skip: assert property (exec && req_q.op == SAS_OP_SKIP_NONZERO |-> // [RULE4]
        skip_take == (rd_data != `SAS_BYTE_ZERO) && !mem_we)
        else $error("nonzero skip decision wrong");
    a_sub_acc_value: assert property (exec && req_q.op == SAS_OP_SUB_TO_ACC |=> // [RULE5]
        acc_out == $past(acc_q) - $past(rd_data))
        else $error("subtract to accumulator wrong");
    a_sub_mem_write: assert property (exec && req_q.op == SAS_OP_SUB_TO_MEM |-> // [RULE6]
        mem_we && mem_wdata == acc_q - rd_data ##1 $stable(acc_out))
        else $error("subtract to memory wrong");
    a_carry_sense: assert property (exec && is_sub(req_q.op) |=> // [RULE7]
        flags_out.c == ($past(acc_q) >= $past(rd_data)) && flags_out.z == ($past(acc_q) == $past(rd_data)))
        else $error("carry or zero flag wrong after subtract");
    a_flags_hold: assert property (exec && !is_sub(req_q.op) |=> $stable(flags_out)) // [RULE8]
        else $error("skip operation changed a flag");

endmodule : sas_exec

// ---- tb_top.sv ----
// Self-checking testbench for the skip-and-subtract execution block.
// Assumes sas_cfg.svh, sas_pkg.sv, sas_dmem.sv and sas_exec.sv are compiled first.
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value t=%0t got %h exp %h", $time, got, exp); end end

module tb_top;
    import sas_pkg::*;

    typedef struct {
        logic [7:0] acc;
        sas_flags_t fl;
        logic skip;
        int lat;
        int dum;
    } sas_tb_note_t;

    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic req_valid_in = 1'b0;
    sas_req_t req_in = '0;
    sas_wr_t preload_in = '0;
    logic acc_load_in = 1'b0;
    logic [7:0] acc_load_data_in = 8'h00;
    logic busy_out, done_out, skip_out, dummy_out;
    logic [7:0] acc_out;
    sas_flags_t flags_out;
    int mismatches = 0;
    int checked = 0;
    int seed = 66;
    int cycles = 0;
    int cnt = 0;
    int dcnt = 0;
    int bcnt = 0;
    logic [7:0] mem_m [256];
    logic [7:0] acc_m = 8'h00;
    sas_flags_t fl_m = '0;
    sas_tb_note_t notes[$];
    sas_tb_note_t nt;
    logic [7:0] tv_a [5] = '{8'h00, 8'h80, 8'h7f, 8'h5a, 8'h10};
    logic [7:0] tv_m [5] = '{8'h01, 8'h01, 8'hff, 8'h5a, 8'h0f};
    logic [7:0] tv_s [3] = '{8'hff, 8'h00, 8'h05};

    sas_exec i_sas_exec (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .req_valid_in(req_valid_in),
        .req_in(req_in),
        .preload_in(preload_in),
        .acc_load_in(acc_load_in),
        .acc_load_data_in(acc_load_data_in),
        .busy_out(busy_out),
        .done_out(done_out),
        .skip_out(skip_out),
        .dummy_out(dummy_out),
        .acc_out(acc_out),
        .flags_out(flags_out)
    );

    always #12.5 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    task automatic preload(input logic [7:0] a, input logic [7:0] d);
        preload_in <= '{1'b1, a, d};
        mem_m[a] = d;
        @(posedge clk_in);
        preload_in <= '0;
        @(posedge clk_in);
    endtask : preload

    task automatic acc_load(input logic [7:0] d);
        acc_load_in <= 1'b1;
        acc_load_data_in <= d;
        acc_m = d;
        @(posedge clk_in);
        acc_load_in <= 1'b0;
        @(posedge clk_in);
    endtask : acc_load

    // Works out the expected outcome, notes it, then issues the request and waits for done.
    task automatic do_op(input sas_op_t op, input logic [7:0] a);
        sas_tb_note_t n;
        logic [7:0] m;
        logic [7:0] r;
        int i;
        int sd;
        m = mem_m[a];
        r = acc_m - m;
        n.skip = 1'b0;
        case (op)
            SAS_OP_INC_SKIP_ZERO: begin
                mem_m[a] = m + 8'h01;
                n.skip = (m == 8'hff);
            end
            SAS_OP_INC_SKIP_ZERO_TO_ACC: begin
                acc_m = m + 8'h01;
                n.skip = (m == 8'hff);
            end
            SAS_OP_SKIP_NONZERO: n.skip = (m != 8'h00);
            default: begin
                fl_m.c = (acc_m >= m);
                fl_m.aux_borrow_flag = (acc_m[3:0] >= m[3:0]);
                sd = int'($signed(acc_m)) - int'($signed(m));
                fl_m.overflow_flag = (sd > 127) || (sd < -128);
                fl_m.z = (r == 8'h00);
                fl_m.compare_zero_flag = (r == 8'h00);
                fl_m.signed_compare_flag = ($signed(acc_m) >= $signed(m));
                if (op == SAS_OP_SUB_TO_ACC)
                    acc_m = r;
                else
                    mem_m[a] = r;
            end
        endcase
        n.acc = acc_m;
        n.fl = fl_m;
        n.lat = n.skip ? 4 : 2;
        n.dum = n.skip ? 2 : 0;
        notes.push_back(n);
        req_valid_in <= 1'b1;
        req_in <= '{op, a};
        @(posedge clk_in);
        // Holding the request and a stray preload one edge into execution checks that both are ignored.
        preload_in <= '{1'b1, a, ~m};
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        preload_in <= '0;
        i = 1;
        while (done_out !== 1'b1 && i < 8) begin
            @(posedge clk_in);
            i++;
        end
        `CHK(done_out, 1'b1)
    endtask : do_op

    // ----------------------------------------------------------------
    // Monitor
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            summarize();
        end
    end

    always @(posedge clk_in) begin
        cnt++;
        if (dummy_out === 1'b1)
            dcnt++;
        if (busy_out === 1'b1)
            bcnt++;
        if (done_out === 1'b1) begin
            if (notes.size() == 0) begin
                mismatches++;
                $display("wrong value t=%0t unexpected completion", $time);
            end else begin
                nt = notes.pop_front();
                `CHK(acc_out, nt.acc)
                `CHK(flags_out, nt.fl)
                `CHK(skip_out, nt.skip)
                `CHK(cnt, nt.lat)
                `CHK(dcnt, nt.dum)
                `CHK(bcnt, nt.lat - 1)
            end
        end
        if (req_valid_in === 1'b1 && busy_out === 1'b0) begin
            cnt = 0;
            dcnt = 0;
            bcnt = 0;
        end
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] rv;
        int k;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        for (int a = 0; a < 8; a++) begin
            rv = 8'($random(seed));
            preload(a[7:0], rv);
        end
        for (int i = 0; i < 5; i++) begin
            acc_load(tv_a[i]);
            preload(8'h00, tv_m[i]);
            do_op(SAS_OP_SUB_TO_ACC, 8'h00);
            acc_load(tv_a[i]);
            do_op(SAS_OP_SUB_TO_MEM, 8'h00);
            do_op(SAS_OP_INC_SKIP_ZERO_TO_ACC, 8'h00);
        end
        for (int i = 0; i < 3; i++) begin
            preload(8'h01, tv_s[i]);
            do_op(SAS_OP_INC_SKIP_ZERO, 8'h01);
            do_op(SAS_OP_SKIP_NONZERO, 8'h01);
            do_op(SAS_OP_INC_SKIP_ZERO_TO_ACC, 8'h01);
            do_op(SAS_OP_INC_SKIP_ZERO_TO_ACC, 8'h01);
        end
        repeat (60) begin
            k = $unsigned($random(seed)) % 7;
            rv = 8'($random(seed));
            if (k == 5)
                preload({5'h00, rv[2:0]}, 8'($random(seed)));
            else if (k == 6)
                acc_load(rv);
            else
                do_op(sas_op_t'(k[2:0]), {5'h00, rv[2:0]});
        end
        repeat (4) @(posedge clk_in);
        `CHK(notes.size(), 0)
        summarize();
    end

endmodule : tb_top
